// ---- frc_drive_model.sv ----
// Floppy drive model: track zero, write protect, index and media change.
// Assumes the bench sets the request levels just after clock edges.
module frc_drive_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Requests from the bench
	input wire logic spinEn,
	input wire logic wpReq,
	input wire logic t0Req,
	input wire logic chgReq,
	// Drive cable
	output logic trackZeroIn,
	output logic writeProtIn,
	output logic indexPulseIn,
	output logic mediaChanged
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] turnCnt_r;
	assign trackZeroIn = t0Req;
	assign writeProtIn = wpReq;
	assign mediaChanged = chgReq;
	// One index pulse every 16 cycles while the disk turns
	assign indexPulseIn = spinEn && turnCnt_r == 4'hF;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) turnCnt_r <= 4'h0;
		else turnCnt_r <= turnCnt_r + 4'h1;
	end
endmodule : frc_drive_model

// ---- frc_pkg.sv ----
// Types for the rate configuration and result status bank.
// Assumes frc_regs.svh supplies the numeric constants.
package frc_pkg;
	// ---------------------------------------------------------------
	// Register modes and command phases
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FRC_MODE_FIRST = 3'h1,
		FRC_MODE_SECOND = 3'h2,
		FRC_MODE_THIRD = 3'h4
	} frc_mode_e;
	typedef enum logic [2:0] {
		FRC_PH_IDLE = 3'h1,
		FRC_PH_EXEC = 3'h2,
		FRC_PH_RESULT = 3'h4
	} frc_phase_e;
	// ---------------------------------------------------------------
	// Complete block state
	// ---------------------------------------------------------------
	typedef struct packed {
		frc_phase_e phase;
		logic [1:0] rate;
		logic precompOff;
		logic density;
		logic [1:0] termCode;
		logic positioningDone;
		logic gearFault;
		logic head;
		logic [1:0] unitSel;
		logic endCyl;
		logic crcFault;
		logic overrun;
		logic sectorMissing;
		logic writeBlocked;
		logic idSyncAbsent;
		logic [6:0] stepCnt;
		logic [1:0] pulseCnt;
		logic pulsePrev;
		logic endSeen;
		logic byteSel;
		logic [7:0] rdata;
	} frc_state_s;
endpackage : frc_pkg

// ---- frc_rate_status.sv ----
// Rate configuration register, density pin and result status bytes 0 and 1.
// Assumes the command sequencer drives the event inputs synchronous to core_clk.
`include "frc_regs.svh"
module frc_rate_status
	import frc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Host register access
	input wire logic [9:0] hostAddr,
	input wire logic hostWr,
	input wire logic hostRd,
	input wire logic [7:0] hostWdata,
	output logic [7:0] hostRdata,
	// Configuration and software resets
	input wire logic identBit,
	input wire logic modeSelectBitB,
	input wire logic dmaEnIn,
	input wire logic driveOutputRegReset,
	input wire logic dsrReset,
	// Drive cable inputs
	input wire logic mediaChanged,
	input wire logic trackZeroIn,
	input wire logic writeProtIn,
	input wire logic indexPulseIn,
	// Sequencer events
	input wire logic cmdStart,
	input wire logic resultStart,
	input wire logic termValid,
	input wire logic [1:0] termCode,
	input wire logic seekDone,
	input wire logic recalActive,
	input wire logic stepPulse,
	input wire logic relSeekOutward,
	input wire logic headIn,
	input wire logic [1:0] unitSelIn,
	input wire logic sectorPastEnd,
	input wire logic transferEnd,
	input wire logic dataCmdEnd,
	input wire logic crcFaultIn,
	input wire logic serviceMiss,
	input wire logic sectorNotFound,
	input wire logic idReadFail,
	input wire logic trackSeqFail,
	input wire logic writeCmdActive,
	input wire logic idSearch,
	input wire logic idMarkSeen,
	input wire logic dataMarkAbsent,
	// Drive and sequencer outputs
	output logic densityOut,
	output logic [1:0] rateSel,
	output logic resultPhase
);
	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic frc_mode_e modeOf(input logic id, input logic sel);
		if (id) begin
			modeOf = FRC_MODE_FIRST;
		end else if (sel) begin
			modeOf = FRC_MODE_SECOND;
		end else begin
			modeOf = FRC_MODE_THIRD;
		end
	endfunction : modeOf
	// High for the two fast rates, low for 300 and 250 kbps
	function automatic logic fastRate(input logic [1:0] r);
		fastRate = (r == `FRC_RATE_1M) || (r == `FRC_RATE_500K);
	endfunction : fastRate
	function automatic logic densityOf(input logic [1:0] r, input logic id);
		densityOf = !fastRate(r) ^ id;
	endfunction : densityOf
	function automatic logic [7:0] st0Of(input frc_state_s s);
		st0Of = {s.termCode, s.positioningDone, s.gearFault, 1'b0, s.head, s.unitSel};
	endfunction : st0Of
	function automatic logic [7:0] st1Of(input frc_state_s s);
		st1Of = {s.endCyl, 1'b0, s.crcFault, s.overrun, 1'b0, s.sectorMissing,
			s.writeBlocked, s.idSyncAbsent};
	endfunction : st1Of
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	frc_state_s s_r;
	frc_state_s s_nxt;
	frc_mode_e mode;
	logic swRst;
	logic rateWr;
	logic isrRd;
	logic dataRd;
	logic clr;
	logic [7:0] isrByte;
	assign mode = modeOf(identBit, modeSelectBitB);
	assign swRst = driveOutputRegReset || dsrReset;
	assign rateWr = hostWr && (hostAddr == `FRC_ADDR_RATE);
	assign isrRd = hostRd && (hostAddr == `FRC_ADDR_RATE);
	assign dataRd = hostRd && (hostAddr == `FRC_ADDR_DATA);
	assign clr = cmdStart || swRst;
	// ---------------------------------------------------------------
	// Input status byte
	// ---------------------------------------------------------------
	always_comb begin
		unique case (mode)
			FRC_MODE_FIRST: begin
				isrByte = {!mediaChanged, `FRC_ISR_FIRST_FILL};
			end
			FRC_MODE_SECOND: begin
				isrByte = {!mediaChanged, `FRC_ISR_SECOND_FILL, s_r.rate, !fastRate(s_r.rate)};
			end
			FRC_MODE_THIRD: begin
				isrByte = {!mediaChanged, `FRC_ISR_THIRD_FILL, dmaEnIn, s_r.precompOff, s_r.rate};
			end
		endcase
	end
	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Rate selection survives software resets
		if (rateWr) begin
			s_nxt.rate = hostWdata[1:0];
			if (mode == FRC_MODE_THIRD) begin
				s_nxt.precompOff = hostWdata[`FRC_PRECOMP_BIT];
			end
		end
		if (!swRst) begin
			s_nxt.density = densityOf(s_r.rate, identBit);
		end
		// Flags clear first, then events set, so an event in the same cycle as cmdStart survives
		if (clr) begin
			s_nxt.termCode = 2'h0;
			s_nxt.positioningDone = 1'b0;
			s_nxt.gearFault = 1'b0;
			s_nxt.endCyl = 1'b0;
			s_nxt.crcFault = 1'b0;
			s_nxt.overrun = 1'b0;
			s_nxt.sectorMissing = 1'b0;
			s_nxt.writeBlocked = 1'b0;
			s_nxt.idSyncAbsent = 1'b0;
			s_nxt.stepCnt = 7'h00;
			s_nxt.pulseCnt = 2'h0;
			s_nxt.endSeen = 1'b0;
			s_nxt.byteSel = 1'b0;
		end
		if (!swRst) begin
			if (termValid) begin
				s_nxt.termCode = termCode;
			end
			if (seekDone) begin
				s_nxt.positioningDone = 1'b1;
			end
			// Step count saturates once the limit is reached
			if (recalActive && stepPulse && (s_r.stepCnt != `FRC_RECAL_STEPS)) begin
				s_nxt.stepCnt = s_r.stepCnt + 7'h01;
			end
			if ((recalActive && !trackZeroIn && (s_r.stepCnt == `FRC_RECAL_STEPS)) || relSeekOutward) begin
				s_nxt.gearFault = 1'b1;
			end
			if (transferEnd) begin
				s_nxt.endSeen = 1'b1;
			end
			if (sectorPastEnd || (dataCmdEnd && !s_r.endSeen && !transferEnd)) begin
				s_nxt.endCyl = 1'b1;
			end
			if (crcFaultIn) begin
				s_nxt.crcFault = 1'b1;
			end
			if (serviceMiss) begin
				s_nxt.overrun = 1'b1;
			end
			if (sectorNotFound || idReadFail || trackSeqFail) begin
				s_nxt.sectorMissing = 1'b1;
			end
			if (writeCmdActive && writeProtIn) begin
				s_nxt.writeBlocked = 1'b1;
			end
			// Index pulses counted on their rising edge while an ID is sought
			if (idMarkSeen || !idSearch) begin
				s_nxt.pulseCnt = 2'h0;
			end else if (indexPulseIn && !s_r.pulsePrev && (s_r.pulseCnt != `FRC_PULSE_LIMIT)) begin
				s_nxt.pulseCnt = s_r.pulseCnt + 2'h1;
			end
			if ((idSearch && !idMarkSeen && (s_r.pulseCnt == `FRC_PULSE_LIMIT)) || dataMarkAbsent) begin
				s_nxt.idSyncAbsent = 1'b1;
			end
		end
		s_nxt.pulsePrev = indexPulseIn;
		// Command phases
		unique case (s_r.phase)
			FRC_PH_IDLE: begin
				if (cmdStart) begin
					s_nxt.phase = FRC_PH_EXEC;
				end
			end
			FRC_PH_EXEC: begin
				if (resultStart) begin
					s_nxt.phase = FRC_PH_RESULT;
					s_nxt.head = headIn;
					s_nxt.unitSel = unitSelIn;
				end
			end
			FRC_PH_RESULT: begin
				if (dataRd) begin
					s_nxt.byteSel = !s_r.byteSel;
					if (s_r.byteSel) begin
						s_nxt.phase = FRC_PH_IDLE;
					end
				end
			end
			default: begin
				s_nxt.phase = FRC_PH_IDLE;
			end
		endcase
		if (swRst) begin
			s_nxt.phase = FRC_PH_IDLE;
		end
		// Read data; the rate register reads back only through the input status byte, in the second and third modes
		s_nxt.rdata = `FRC_ZERO_BYTE;
		if (isrRd) begin
			s_nxt.rdata = isrByte;
		end else if (dataRd && (s_r.phase == FRC_PH_RESULT)) begin
			s_nxt.rdata = s_r.byteSel ? st1Of(s_r) : st0Of(s_r);
		end
	end
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.phase <= FRC_PH_IDLE;
			s_r.rate <= `FRC_RATE_RST;
			s_r.density <= `FRC_DENS_RST;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign hostRdata = s_r.rdata;
	assign densityOut = s_r.density;
	assign rateSel = s_r.rate;
	assign resultPhase = (s_r.phase == FRC_PH_RESULT);
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic densExp;
	logic [7:0] st0Now;
	logic [7:0] st1Now;
	assign densExp = densityOf(s_r.rate, identBit);
	assign st0Now = st0Of(s_r);
	assign st1Now = st1Of(s_r);
	a_rate_write: assert property (rateWr |=> rateSel == $past(hostWdata[1:0]))
		else $error("rate write not stored");
	a_rate_reset: assert property ($rose(rstn) |-> rateSel == `FRC_RATE_RST)
		else $error("rate reset value wrong");
	a_precomp_keep: assert property (!rateWr |=> $stable(s_r.precompOff))
		else $error("precomp flag changed without write");
	a_density_soft: assert property (swRst |=> $stable(densityOut))
		else $error("density moved during soft reset");
	a_density_map: assert property (!swRst |=> densityOut == $past(densExp))
		else $error("density encoding wrong");
	a_media_inv: assert property (isrRd |=> hostRdata[7] == !$past(mediaChanged))
		else $error("media change bit not inverted");
	a_result_first: assert property (dataRd && resultPhase && !s_r.byteSel
		|=> hostRdata == $past(st0Now) ##1 !resultPhase || s_r.byteSel)
		else $error("status byte 0 not presented");
	a_unused_zero: assert property (dataRd && resultPhase |=> hostRdata[3] == 1'b0)
		else $error("unused status bit set");
	a_gear_set: assert property (recalActive && !trackZeroIn && s_r.stepCnt == `FRC_RECAL_STEPS
		&& !swRst |=> s_r.gearFault)
		else $error("gear fault missed after steps");
	a_id_absent: assert property (idSearch && !idMarkSeen && s_r.pulseCnt == `FRC_PULSE_LIMIT
		&& !swRst |=> s_r.idSyncAbsent)
		else $error("missing mark not flagged");
	a_write_block: assert property (writeCmdActive && writeProtIn && !swRst |=> s_r.writeBlocked)
		else $error("write protect not flagged");
	a_rate_hold: assert property (!rateWr |=> $stable(rateSel))
		else $error("rate changed without write");
	a_precomp_other: assert property (rateWr && mode != FRC_MODE_THIRD |=> $stable(s_r.precompOff))
		else $error("precomp flag stored outside third mode");
	a_precomp_write: assert property (rateWr && mode == FRC_MODE_THIRD
		|=> s_r.precompOff == $past(hostWdata[`FRC_PRECOMP_BIT]))
		else $error("precomp flag not stored");
	// ---------------------------------------------------------------
	// Status flag assertions
	// ---------------------------------------------------------------
	a_term_code: assert property (termValid && !swRst |=> s_r.termCode == $past(termCode))
		else $error("termination code not latched");
	a_seek_done: assert property (seekDone && !swRst |=> s_r.positioningDone)
		else $error("positioning done not flagged");
	a_gear_outward: assert property (relSeekOutward && !swRst |=> s_r.gearFault)
		else $error("outward step fault not flagged");
	a_step_sat: assert property (s_r.stepCnt <= `FRC_RECAL_STEPS)
		else $error("step count past limit");
	a_head_unit: assert property (resultStart && s_r.phase == FRC_PH_EXEC && !swRst
		|=> s_r.head == $past(headIn) && s_r.unitSel == $past(unitSelIn))
		else $error("head or unit not captured");
	a_end_cyl: assert property (sectorPastEnd && !swRst |=> s_r.endCyl)
		else $error("end of track not flagged");
	a_crc_fault: assert property (crcFaultIn && !swRst |=> s_r.crcFault)
		else $error("crc fault not flagged");
	a_service_miss: assert property (serviceMiss && !swRst |=> s_r.overrun)
		else $error("overrun not flagged");
	a_sector_miss: assert property ((sectorNotFound || idReadFail || trackSeqFail) && !swRst
		|=> s_r.sectorMissing)
		else $error("missing sector not flagged");
	a_data_mark: assert property (dataMarkAbsent && !swRst |=> s_r.idSyncAbsent)
		else $error("missing data mark not flagged");
	a_pulse_sat: assert property (s_r.pulseCnt <= `FRC_PULSE_LIMIT)
		else $error("index count past limit");
	// ---------------------------------------------------------------
	// Result byte and command phase assertions
	// ---------------------------------------------------------------
	a_result_second: assert property (dataRd && resultPhase && s_r.byteSel
		|=> hostRdata == $past(st1Now) && !resultPhase)
		else $error("status byte 1 not presented");
	a_status1_zero: assert property (dataRd && resultPhase && s_r.byteSel
		|=> hostRdata[6] == 1'b0 && hostRdata[3] == 1'b0)
		else $error("unused status 1 bit set");
	a_idle_read: assert property (dataRd && !resultPhase |=> hostRdata == `FRC_ZERO_BYTE)
		else $error("data read outside result phase");
	a_phase_legal: assert property ($onehot(s_r.phase))
		else $error("command phase code illegal");
	// ---------------------------------------------------------------
	// Cover points
	// ---------------------------------------------------------------
	c_result_read: cover property (resultPhase && dataRd ##[1:8] resultPhase && dataRd);
	c_rate_fast: cover property (rateWr && hostWdata[1:0] == `FRC_RATE_1M);
	c_soft_reset: cover property (swRst ##1 !swRst);
	c_gear_fault: cover property (s_r.gearFault && resultPhase);
	c_third_write: cover property (rateWr && mode == FRC_MODE_THIRD);
endmodule : frc_rate_status

// ---- frc_rate_status_tb_top.sv ----
// Self-checking bench for the rate configuration and status bank.
// Assumes frc_pkg, the design and the drive model are compiled first.
`include "frc_regs.svh"
module frc_rate_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rstn = 0, hostWr = 0, hostRd = 0, identBit = 1, modeSelectBitB = 1;
	logic dmaEnIn = 0, driveOutputRegReset = 0, dsrReset = 0, cmdStart = 0, resultStart = 0, termValid = 0;
	logic recalActive = 0, stepPulse = 0, headIn = 0, idSearch = 0, spinEn = 0, chg = 0;
	logic [1:0] termCode = 0, unitSelIn = 0;
	logic [9:0] hostAddr = 0;
	logic [7:0] hostWdata = 0;
	logic [11:0] ev = 0;
	wire [7:0] hostRdata;
	wire [1:0] rateSel;
	wire densityOut, resultPhase, trackZeroIn, writeProtIn, indexPulseIn, mediaChanged;
	int num_errors = 0, compares = 0;
	always #2 core_clk = ~core_clk;
	frc_rate_status u_frc_rate_status (.core_clk, .rstn, .hostAddr, .hostWr, .hostRd, .hostWdata,
		.hostRdata, .identBit, .modeSelectBitB, .dmaEnIn, .driveOutputRegReset, .dsrReset, .mediaChanged,
		.trackZeroIn, .writeProtIn, .indexPulseIn, .cmdStart, .resultStart, .termValid, .termCode,
		.seekDone(ev[0]), .recalActive, .stepPulse, .relSeekOutward(ev[1]), .headIn, .unitSelIn,
		.sectorPastEnd(ev[2]), .transferEnd(ev[11]), .dataCmdEnd(ev[3]), .crcFaultIn(ev[4]),
		.serviceMiss(ev[5]), .sectorNotFound(ev[6]), .idReadFail(ev[7]), .trackSeqFail(ev[8]),
		.writeCmdActive(ev[10]), .idSearch, .idMarkSeen(1'b0), .dataMarkAbsent(ev[9]),
		.densityOut, .rateSel, .resultPhase);
	frc_drive_model u_frc_drive_model (.core_clk, .rstn, .spinEn, .wpReq(1'b1), .t0Req(1'b0),
		.chgReq(chg), .trackZeroIn, .writeProtIn, .indexPulseIn, .mediaChanged);
	// ---------------------------------------------------------------
	// Expectations and bus tasks
	// ---------------------------------------------------------------
	function logic exp_dens(logic [1:0] r, logic id);
		return (r == 2'h3 || r == 2'h0) ? id : !id;
	endfunction : exp_dens
	function logic [7:0] exp_s0(logic [1:0] tc, logic [11:0] v);
		return {tc, v[0], v[1], 1'b0, headIn, unitSelIn};
	endfunction : exp_s0
	function logic [7:0] exp_s1(logic [11:0] v);
		return {v[2] | (v[3] & !v[11]), 1'b0, v[4], v[5], 1'b0, |v[8:6], v[10], v[9]};
	endfunction : exp_s1
	task chk(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task clk(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : clk
	task wr(logic [9:0] a, logic [7:0] d);
		@(posedge core_clk);
		hostWr <= 1;
		hostAddr <= a;
		hostWdata <= d;
		@(posedge core_clk);
		hostWr <= 0;
	endtask : wr
	task rd(logic [9:0] a, output logic [7:0] d);
		@(posedge core_clk);
		hostRd <= 1;
		hostAddr <= a;
		@(posedge core_clk);
		hostRd <= 0;
		#1 d = hostRdata;
	endtask : rd
	task start_cmd;
		@(posedge core_clk);
		headIn <= $urandom;
		unitSelIn <= $urandom;
		cmdStart <= 1;
		@(posedge core_clk);
		cmdStart <= 0;
	endtask : start_cmd
	task finish_cmd(logic [1:0] tc, logic [7:0] e0, logic [7:0] e1);
		logic [7:0] d;
		@(posedge core_clk);
		termValid <= 1;
		termCode <= tc;
		@(posedge core_clk);
		termValid <= 0;
		resultStart <= 1;
		@(posedge core_clk);
		resultStart <= 0;
		clk(1);
		chk("resultPhase", 8'h01, resultPhase);
		rd(`FRC_ADDR_DATA, d);
		chk("status0", e0, d);
		rd(`FRC_ADDR_DATA, d);
		chk("status1", e1, d);
		chk("resultPhase", 8'h00, resultPhase);
		rd(`FRC_ADDR_DATA, d);
		chk("idleData", 8'h00, d);
	endtask : finish_cmd
	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge core_clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] d;
		logic [1:0] r;
		logic [11:0] v;
		void'($urandom(71179));
		clk(9);
		chk("rateSel", 8'h02, rateSel);
		chk("densityOut", 8'h01, densityOut);
		@(posedge core_clk);
		rstn <= 1;
		rd(`FRC_ADDR_RATE, d);
		chk("inStatus", 8'h80, d);
		rd(10'h3F0, d);
		chk("unmapped", 8'h00, d);
		chk("densityOut", exp_dens(2'h2, identBit), densityOut);
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			r = $urandom;
			@(posedge core_clk);
			identBit <= $urandom;
			wr(`FRC_ADDR_RATE, {6'h00, r});
			clk(2);
			chk("rateSel", r, rateSel);
			chk("densityOut", exp_dens(r, identBit), densityOut);
		end
		$display("rate test done");
		@(posedge core_clk);
		identBit <= 0;
		modeSelectBitB <= 0;
		dmaEnIn <= 1;
		chg <= 1;
		wr(`FRC_ADDR_RATE, 8'h05);
		for (int k = 1; k < 3; k++) begin
			@(posedge core_clk);
			{dsrReset, driveOutputRegReset} <= 2'(k);
			identBit <= 1;
			clk(3);
			chk("rateSel", 8'h01, rateSel);
			chk("densityOut", 8'h01, densityOut);
			@(posedge core_clk);
			{dsrReset, driveOutputRegReset} <= 2'h0;
			identBit <= 0;
			rd(`FRC_ADDR_RATE, d);
			chk("inStatus", 8'h0D, d);
		end
		$display("third mode test done");
		for (int i = 0; i < 16; i++) begin
			v = $urandom;
			r = $urandom;
			start_cmd();
			@(posedge core_clk);
			ev <= v;
			@(posedge core_clk);
			ev <= 0;
			finish_cmd(r, exp_s0(r, v), exp_s1(v));
		end
		$display("status test done");
		for (int n = 79; n < 81; n++) begin
			start_cmd();
			@(posedge core_clk);
			recalActive <= 1;
			idSearch <= 1;
			spinEn <= 1;
			repeat (n) begin
				@(posedge core_clk);
				stepPulse <= 1;
				@(posedge core_clk);
				stepPulse <= 0;
			end
			repeat (3) @(posedge core_clk);
			recalActive <= 0;
			idSearch <= 0;
			spinEn <= 0;
			finish_cmd(2'h0, exp_s0(2'h0, 12'h000) | {3'h0, n == 80, 4'h0}, 8'h01);
		end
		$display("step and index test done");
		tally_and_finish();
	end
endmodule : frc_rate_status_tb_top

// ---- frc_regs.svh ----
// Addresses, bit positions, reset values and counts of the rate/status bank.
// Assumes a 10-bit host I/O address and an 8-bit host data bus.
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH
// ---------------------------------------------------------------
// Host addresses
// ---------------------------------------------------------------
`define FRC_ADDR_RATE 10'h3F7
`define FRC_ADDR_DATA 10'h3F5
// ---------------------------------------------------------------
// Rate configuration fields and reset values
// ---------------------------------------------------------------
`define FRC_RATE_RST 2'h2
`define FRC_PRECOMP_BIT 2
`define FRC_DENS_RST 1'h1
`define FRC_RATE_1M 2'h3
`define FRC_RATE_500K 2'h0
// ---------------------------------------------------------------
// Input status layout
// ---------------------------------------------------------------
`define FRC_ISR_SECOND_FILL 4'hF
`define FRC_ISR_THIRD_FILL 3'h0
`define FRC_ISR_FIRST_FILL 7'h00
// ---------------------------------------------------------------
// Counts
// ---------------------------------------------------------------
`define FRC_RECAL_STEPS 7'h50
`define FRC_PULSE_LIMIT 2'h2
`define FRC_ZERO_BYTE 8'h00
`endif
